/* core/mcc_mode_config.sv */
/*
  Mode and configuration control of the copper-to-fiber media converter:
  strap latching, management registers on APB, mode resolution and line
  style selection.
  Assumes strap comparators deliver level codes and link detectors deliver
  abilities; every pin input is asynchronous and is synchronised here.
*/
`timescale 1ns/1ps
module mcc_mode_config #(
  parameter int unsigned STRAP_DELAY = mcc_pkg::STRAP_CYCLES
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [9:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Strap comparator codes
  input wire logic [1:0] speed_strap,
  input wire logic [1:0] duplex_strap,
  input wire logic [1:0] copper_port_style_strap,
  input wire logic [1:0] fiber_port_style_strap,
  input wire logic [1:0] addr_bit4_warning_strap,
  input wire logic [1:0] addr_bits_upper_strap,
  input wire logic [1:0] addr_bits_lower_strap,
  // Backup link pin
  input wire logic backup_link_pin_i,
  output logic backup_link_pin_o,
  output logic backup_link_pin_oe_n,
  input wire logic backup_fail,
  // Control pins
  input wire logic copper_output_disable_n,
  input wire logic fiber_output_disable_n,
  input wire logic power_down_n,
  // Link detection
  input wire logic copper_an_capable,
  input wire logic fiber_an_capable,
  input wire logic fiber_flp_rx,
  input wire logic [3:0] copper_abil,
  input wire logic [3:0] fiber_abil,
  // Outputs
  output logic [5:0] mgmt_addr,
  output logic [3:0] copper_adv,
  output logic [3:0] fiber_adv,
  output logic [1:0] resolved_abil,
  output logic own_flp_en,
  output logic link_integrity_warning,
  output logic transparent_active,
  output logic copper_pecl,
  output logic fiber_differential,
  output logic fiber_peaking_en,
  output logic [1:0] copper_coding,
  output logic [1:0] fiber_coding,
  output logic copper_out_en,
  output logic fiber_out_en,
  output logic strap_latched
);
  // Synchroniser stages for pin inputs.
  logic [19:0] s1_q;
  logic [19:0] s2_q;
  logic [31:0] pin_s1_q;
  logic [31:0] pin_s2_q;
  logic [15:0] r28_q;
  logic [15:0] r30_q;
  logic [15:0] r31_q;
  logic pdn_prev_q;
  logic rst30_prev_q;
  logic start;
  logic latch_pulse;
  logic busy;
  logic [1:0] spd_c;
  logic [1:0] dup_c;
  logic [1:0] cu_c;
  logic [1:0] fo_c;
  logic [1:0] a4_c;
  logic [1:0] a32_c;
  logic [1:0] a10_c;
  logic bck_c;
  logic cu_off_c;
  logic fo_off_c;
  logic pdn_c;
  logic cu_an_c;
  logic fo_an_c;
  logic fo_flp_c;
  logic fail_c;
  logic [3:0] cu_ab_c;
  logic [3:0] fo_ab_c;
  logic wr_en;
  logic [15:0] wdat;
  logic [31:0] rd_d;
  logic addr_ok;
  logic both_speeds;
  logic relay_mode;
  logic [3:0] common;

  typedef enum logic [2:0] {
    MCC_FORCED = 3'b001,
    MCC_NONTR = 3'b010,
    MCC_TRANSP = 3'b100
  } mcc_mode_e;
  mcc_mode_e mode;

  // Highest set ability bit in ranking order.
  function automatic logic [1:0] mcc_best(input logic [3:0] a);
    logic [1:0] r;
    r = mcc_pkg::ABIL_10HD;
    if (a[1]) r = mcc_pkg::ABIL_10FD;
    if (a[2]) r = mcc_pkg::ABIL_100HD;
    if (a[3]) r = mcc_pkg::ABIL_100FD;
    return r;
  endfunction : mcc_best

  // Converts a three-level code to a 6-bit address fragment of 2 bits.
  function automatic logic [1:0] mcc_lvl(input logic [1:0] c);
    return c;
  endfunction : mcc_lvl

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      // Active-low pins reset to their idle level, so release makes no false edge.
      s1_q <= 20'h0001C;
      s2_q <= 20'h0001C;
      pin_s1_q <= 32'h00000000;
      pin_s2_q <= 32'h00000000;
    end else begin
      s1_q <= {speed_strap, duplex_strap, copper_port_style_strap, fiber_port_style_strap,
               addr_bit4_warning_strap, addr_bits_upper_strap, addr_bits_lower_strap,
               backup_link_pin_i, copper_output_disable_n, fiber_output_disable_n,
               power_down_n, copper_an_capable, fiber_an_capable};
      s2_q <= s1_q;
      pin_s1_q <= {22'h000000, fiber_flp_rx, backup_fail, copper_abil, fiber_abil};
      pin_s2_q <= pin_s1_q;
    end
  end

  assign {spd_c, dup_c, cu_c, fo_c, a4_c, a32_c, a10_c, bck_c, cu_off_c, fo_off_c, pdn_c,
          cu_an_c, fo_an_c} = s2_q;
  assign {fo_flp_c, fail_c, cu_ab_c, fo_ab_c} = pin_s2_q[9:0];

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      pdn_prev_q <= 1'b1;
      rst30_prev_q <= 1'b0;
    end else begin
      pdn_prev_q <= pdn_c;
      rst30_prev_q <= r30_q[mcc_pkg::R30_MGMT_RESET];
    end
  end
  assign start = (!pdn_prev_q && pdn_c) || (rst30_prev_q && !r30_q[mcc_pkg::R30_MGMT_RESET]);

  mcc_strap_timer #(
    .DELAY_CYCLES(STRAP_DELAY)
  ) u_timer (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .start(start),
    .latch_pulse(latch_pulse),
    .busy(busy)
  );
  assign strap_latched = !busy;

  // APB decode; zero wait states, unmapped reads zero with error.
  assign addr_ok = (paddr == mcc_pkg::ADDR_REG28) || (paddr == mcc_pkg::ADDR_REG30) ||
                   (paddr == mcc_pkg::ADDR_REG31) || (paddr == mcc_pkg::ADDR_STAT);
  assign pready = 1'b1;
  assign pslverr = psel && penable && !addr_ok;
  assign wr_en = psel && penable && pwrite;
  assign wdat = pwdata[15:0];

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      r30_q <= mcc_pkg::R30_RESET;
    end else if (wr_en && paddr == mcc_pkg::ADDR_REG30) begin
      r30_q <= wdat;
    end else if (latch_pulse) begin
      r30_q <= r30_q;
      r30_q[mcc_pkg::R30_AN_DISABLE] <= (spd_c != mcc_pkg::LVL3_MID);
      r30_q[mcc_pkg::R30_SINGLE_SPD] <= (spd_c != mcc_pkg::LVL3_MID);
      r30_q[mcc_pkg::R30_SEL_10] <= (spd_c == mcc_pkg::LVL3_GND);
      r30_q[mcc_pkg::R30_NON_TRANSP] <= (dup_c != mcc_pkg::LVL3_MID);
      r30_q[mcc_pkg::R30_NO_ADV_FD] <= (dup_c == mcc_pkg::LVL3_GND);
      r30_q[mcc_pkg::R30_NO_ADV_HD] <= 1'b0;
      r30_q[mcc_pkg::R30_MGMT_RESET] <= 1'b0;
      r30_q[mcc_pkg::R30_WARN_EN] <= (a4_c != mcc_pkg::LVL3_GND);
      r30_q[mcc_pkg::R30_COPPER_PECL] <= (cu_c != mcc_pkg::LVL4_GND);
      r30_q[mcc_pkg::R30_FIBER_STYLE] <= (fo_c == mcc_pkg::LVL4_THIRD);
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      r28_q <= mcc_pkg::R28_RESET;
    end else if (wr_en && paddr == mcc_pkg::ADDR_REG28) begin
      r28_q <= wdat;
    end else if (latch_pulse) begin
      r28_q[mcc_pkg::R28_BACKUP_EN] <= bck_c;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      r31_q <= mcc_pkg::R31_RESET;
    end else if (wr_en && paddr == mcc_pkg::ADDR_REG31) begin
      r31_q <= wdat;
    end
  end

  // Mode resolution.
  assign both_speeds = !r30_q[mcc_pkg::R30_SINGLE_SPD] && !r30_q[mcc_pkg::R30_AN_DISABLE];
  always_comb begin
    if (!both_speeds) begin
      mode = MCC_FORCED;
    end else if (r30_q[mcc_pkg::R30_NON_TRANSP]) begin
      mode = MCC_NONTR;
    end else begin
      mode = MCC_TRANSP;
    end
  end

  assign relay_mode = (mode == MCC_TRANSP) ||
                      (mode == MCC_NONTR && cu_an_c && fo_an_c);
  assign transparent_active = relay_mode;

  assign common = cu_ab_c & fo_ab_c;

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      copper_adv <= 4'h0;
      fiber_adv <= 4'h0;
      resolved_abil <= mcc_pkg::ABIL_10HD;
      own_flp_en <= 1'b0;
    end else begin
      unique case (mode)
        MCC_TRANSP: begin
          copper_adv <= fo_ab_c;
          fiber_adv <= cu_ab_c;
          own_flp_en <= 1'b0;
        end
        MCC_NONTR: begin
          if (relay_mode) begin
            copper_adv <= fo_ab_c;
            fiber_adv <= cu_ab_c;
          end else begin
            copper_adv <= {!r30_q[mcc_pkg::R30_NO_ADV_FD], !r30_q[mcc_pkg::R30_NO_ADV_HD],
                           !r30_q[mcc_pkg::R30_NO_ADV_FD], !r30_q[mcc_pkg::R30_NO_ADV_HD]};
            fiber_adv <= cu_ab_c;
          end
          own_flp_en <= cu_an_c && !fo_flp_c && !fo_an_c;
        end
        MCC_FORCED: begin
          copper_adv <= 4'h0;
          fiber_adv <= 4'h0;
          own_flp_en <= 1'b0;
        end
      endcase
      resolved_abil <= (mode == MCC_FORCED) ?
                       (r30_q[mcc_pkg::R30_SEL_10] ? mcc_pkg::ABIL_10HD : mcc_pkg::ABIL_100HD) :
                       mcc_best(common);
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      link_integrity_warning <= 1'b0;
    end else begin
      link_integrity_warning <= r30_q[mcc_pkg::R30_WARN_EN] && (mode == MCC_FORCED);
    end
  end

  // Line styles and codings.
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      copper_pecl <= 1'b0;
      fiber_differential <= 1'b0;
      fiber_peaking_en <= 1'b0;
      copper_coding <= mcc_pkg::CU_MLT3;
      fiber_coding <= mcc_pkg::FO_NRZI;
    end else begin
      copper_pecl <= r30_q[mcc_pkg::R30_COPPER_PECL];
      fiber_differential <= r30_q[mcc_pkg::R30_FIBER_STYLE];
      fiber_peaking_en <= !r30_q[mcc_pkg::R30_FIBER_STYLE];
      if (r30_q[mcc_pkg::R30_COPPER_PECL]) begin
        copper_coding <= mcc_pkg::CU_PECL;
      end else if (own_flp_en || (relay_mode && fo_flp_c)) begin
        copper_coding <= mcc_pkg::CU_FLP;
      end else if (resolved_abil[1]) begin
        copper_coding <= mcc_pkg::CU_MLT3;
      end else begin
        copper_coding <= mcc_pkg::CU_MANCH;
      end
      if (relay_mode && cu_an_c) begin
        fiber_coding <= mcc_pkg::FO_FLNP;
      end else if (resolved_abil[1]) begin
        fiber_coding <= mcc_pkg::FO_NRZI;
      end else if (cu_ab_c == 4'h0) begin
        fiber_coding <= mcc_pkg::FO_IDLE;
      end else begin
        fiber_coding <= mcc_pkg::FO_MANCH;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      mgmt_addr <= 6'h00;
      copper_out_en <= 1'b0;
      fiber_out_en <= 1'b0;
    end else begin
      mgmt_addr <= {mcc_lvl(a4_c), mcc_lvl(a32_c), mcc_lvl(a10_c)};
      copper_out_en <= cu_off_c && pdn_c && !r31_q[mcc_pkg::R31_COPPER_OFF] &&
                       !r31_q[mcc_pkg::R31_POWER_DOWN] && !busy;
      fiber_out_en <= fo_off_c && pdn_c && !r31_q[mcc_pkg::R31_FIBER_OFF] &&
                      !r31_q[mcc_pkg::R31_POWER_DOWN] && !busy;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      backup_link_pin_o <= 1'b1;
      backup_link_pin_oe_n <= 1'b1;
    end else begin
      backup_link_pin_o <= fail_c;
      backup_link_pin_oe_n <= busy || !r28_q[mcc_pkg::R28_BACKUP_EN];
    end
  end

  // Read mux; status word shows the block's own resolved state.
  always_comb begin
    rd_d = 32'h00000000;
    unique case (paddr)
      mcc_pkg::ADDR_REG28: rd_d = {16'h0000, r28_q};
      mcc_pkg::ADDR_REG30: rd_d = {16'h0000, r30_q};
      mcc_pkg::ADDR_REG31: rd_d = {16'h0000, r31_q};
      mcc_pkg::ADDR_STAT: rd_d = {23'h000000, strap_latched, own_flp_en, relay_mode,
                                  link_integrity_warning, resolved_abil, mode};
      default: rd_d = 32'h00000000;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      prdata <= 32'h00000000;
    end else if (psel && !penable) begin
      prdata <= rd_d;
    end
  end
endmodule : mcc_mode_config

/* core/mcc_pkg.sv */
/*
  Shared constants for the media converter mode and configuration block:
  register offsets, field positions, strap level codes and strap timing.
  Assumes a 200 MHz system clock and 32-bit APB access.
*/
package mcc_pkg;
  localparam int unsigned CLK_MHZ = 200;
  // Byte offsets of the management registers on APB (index times four).
  localparam logic [7:0] REG28_IDX = 8'h1C;
  localparam logic [7:0] REG30_IDX = 8'h1E;
  localparam logic [7:0] REG31_IDX = 8'h1F;
  localparam logic [7:0] STAT_IDX = 8'h20;
  localparam logic [9:0] ADDR_REG28 = {REG28_IDX, 2'b00};
  localparam logic [9:0] ADDR_REG30 = {REG30_IDX, 2'b00};
  localparam logic [9:0] ADDR_REG31 = {REG31_IDX, 2'b00};
  localparam logic [9:0] ADDR_STAT = {STAT_IDX, 2'b00};
  // Register 30 fields.
  localparam int unsigned R30_NO_ADV_HD = 15;
  localparam int unsigned R30_AN_DISABLE = 14;
  localparam int unsigned R30_MGMT_RESET = 13;
  localparam int unsigned R30_WARN_EN = 12;
  localparam int unsigned R30_NON_TRANSP = 11;
  localparam int unsigned R30_NO_ADV_FD = 10;
  localparam int unsigned R30_SINGLE_SPD = 9;
  localparam int unsigned R30_SEL_10 = 8;
  localparam int unsigned R30_FIBER_STYLE = 7;
  localparam int unsigned R30_COPPER_PECL = 3;
  // Register 28 fields.
  localparam int unsigned R28_BACKUP_EN = 1;
  // Register 31 fields.
  localparam int unsigned R31_POWER_DOWN = 15;
  localparam int unsigned R31_FIBER_OFF = 14;
  localparam int unsigned R31_COPPER_OFF = 13;
  // Reset values.
  localparam logic [15:0] R28_RESET = 16'h0000;
  localparam logic [15:0] R30_RESET = 16'h0000;
  localparam logic [15:0] R31_RESET = 16'h0000;
  // Three-level strap codes from the comparators.
  localparam logic [1:0] LVL3_GND = 2'h0;
  localparam logic [1:0] LVL3_MID = 2'h1;
  localparam logic [1:0] LVL3_VCC = 2'h2;
  // Four-level strap codes: ground, one third, two thirds, supply.
  localparam logic [1:0] LVL4_GND = 2'h0;
  localparam logic [1:0] LVL4_THIRD = 2'h1;
  localparam logic [1:0] LVL4_TWO_THIRD = 2'h2;
  localparam logic [1:0] LVL4_VCC = 2'h3;
  // Strap sampling delay, window 3 to 8 us; 5 us is taken.
  localparam int unsigned STRAP_MIN_US = 3;
  localparam int unsigned STRAP_MAX_US = 8;
  localparam int unsigned STRAP_DELAY_US = 5;
  localparam int unsigned STRAP_CYCLES = STRAP_DELAY_US * CLK_MHZ;
  // Ability ranking codes, lowest to highest.
  localparam logic [1:0] ABIL_10HD = 2'h0;
  localparam logic [1:0] ABIL_10FD = 2'h1;
  localparam logic [1:0] ABIL_100HD = 2'h2;
  localparam logic [1:0] ABIL_100FD = 2'h3;
  // Copper line coding selections.
  localparam logic [1:0] CU_MLT3 = 2'h0;
  localparam logic [1:0] CU_MANCH = 2'h1;
  localparam logic [1:0] CU_FLP = 2'h2;
  localparam logic [1:0] CU_PECL = 2'h3;
  // Fiber line coding selections.
  localparam logic [1:0] FO_NRZI = 2'h0;
  localparam logic [1:0] FO_MANCH = 2'h1;
  localparam logic [1:0] FO_FLNP = 2'h2;
  localparam logic [1:0] FO_IDLE = 2'h3;
endpackage : mcc_pkg

/* core/mcc_strap_timer.sv */
/*
  Strap latch timer: counts the sampling delay after a trigger and pulses
  once when the straps are to be latched.
  Assumes the trigger is a one-cycle pulse on mclk.
*/
`timescale 1ns/1ps
module mcc_strap_timer #(
  parameter int unsigned DELAY_CYCLES = 1000
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // Control
  input wire logic start,
  output logic latch_pulse,
  output logic busy
);
  logic [15:0] cnt_q;
  logic busy_q;

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      busy_q <= 1'b1;
      cnt_q <= 16'h0000;
    end else if (start) begin
      busy_q <= 1'b1;
      cnt_q <= 16'h0000;
    end else if (busy_q) begin
      if (cnt_q == 16'(DELAY_CYCLES - 1)) begin
        busy_q <= 1'b0;
      end
      cnt_q <= cnt_q + 16'h0001;
    end
  end

  assign latch_pulse = busy_q && !start && (cnt_q == 16'(DELAY_CYCLES - 1));
  assign busy = busy_q;
endmodule : mcc_strap_timer

/* bench/mcc_mode_config_monitor.sv */
/*
  Checker for the mode and configuration block, bound to its top ports.
  Assumes one clock domain with a synchronous active-high reset.
*/
`timescale 1ns/1ps
module mcc_mode_config_monitor #(
  parameter int unsigned STRAP_DELAY = 1000
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic [9:0] paddr,
  input wire logic pready,
  input wire logic pslverr,
  // Pins and detectors
  input wire logic [1:0] addr_bit4_warning_strap,
  input wire logic [1:0] addr_bits_upper_strap,
  input wire logic [1:0] addr_bits_lower_strap,
  input wire logic copper_output_disable_n,
  input wire logic fiber_output_disable_n,
  input wire logic power_down_n,
  input wire logic fiber_flp_rx,
  input wire logic [3:0] copper_abil,
  input wire logic [3:0] fiber_abil,
  // Outputs
  input wire logic [5:0] mgmt_addr,
  input wire logic [3:0] copper_adv,
  input wire logic [3:0] fiber_adv,
  input wire logic own_flp_en,
  input wire logic link_integrity_warning,
  input wire logic transparent_active,
  input wire logic copper_out_en,
  input wire logic fiber_out_en,
  input wire logic strap_latched
);
  logic [15:0] wait_q;
  logic [5:0] pin_addr;
  logic mapped;
  assign pin_addr = {addr_bit4_warning_strap, addr_bits_upper_strap, addr_bits_lower_strap};
  assign mapped = paddr inside {mcc_pkg::ADDR_REG28, mcc_pkg::ADDR_REG30,
    mcc_pkg::ADDR_REG31, mcc_pkg::ADDR_STAT};
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (sys_rst);
  // Counts the latch wait, so a timer that never ends is caught in bounded time.
  always_ff @(posedge mclk) begin
    if (sys_rst || strap_latched || !power_down_n) begin
      wait_q <= 16'h0000;
    end else begin
      wait_q <= wait_q + 16'h0001;
    end
  end
  sequence s_cu_off;
    !copper_output_disable_n [*4];
  endsequence
  sequence s_fo_off;
    !fiber_output_disable_n [*4];
  endsequence
  sequence s_addr_steady;
    $stable(pin_addr) [*4];
  endsequence
  sequence s_relay;
    (strap_latched && transparent_active && $stable(copper_abil) && $stable(fiber_abil)) [*5];
  endsequence
  chk_pready_zero_wait: assert property (psel && penable |-> pready)
    else $error("pready low in access phase");
  chk_unmapped_error: assert property (psel && penable && !mapped |-> pslverr)
    else $error("no error on unmapped access");
  chk_warn_transp_off: assert property (transparent_active [*3] |-> !link_integrity_warning)
    else $error("warning active in transparent mode");
  chk_cu_disable_off: assert property (s_cu_off |-> !copper_out_en)
    else $error("copper output on while disabled");
  chk_fo_disable_off: assert property (s_fo_off |-> !fiber_out_en)
    else $error("fiber output on while disabled");
  chk_flp_suppress: assert property (fiber_flp_rx [*4] |-> !own_flp_en)
    else $error("own bursts during fiber bursts");
  chk_addr_live: assert property (s_addr_steady |-> mgmt_addr == pin_addr)
    else $error("address does not follow pins");
  chk_relay_mirror: assert property (s_relay |-> fiber_adv == copper_abil && copper_adv == fiber_abil)
    else $error("abilities not relayed unchanged");
  chk_latch_bound: assert property (!strap_latched |-> wait_q <= STRAP_DELAY + 8)
    else $error("strap latch late");
  chk_latch_early: assert property ($rose(strap_latched) |-> wait_q >= STRAP_DELAY - 3)
    else $error("strap latch early");
endmodule : mcc_mode_config_monitor

/* bench/mcc_link_partner.sv */
/*
  Copper and fiber link partners as seen by the converter's detectors.
  Assumes the bench sets what each partner offers between clock edges.
*/
`timescale 1ns/1ps
module mcc_link_partner (
  // Clock
  input wire logic mclk,
  // Scenario controls
  input wire logic cu_neg,
  input wire logic fo_neg,
  input wire logic fo_burst,
  input wire logic [3:0] cu_offer,
  input wire logic [3:0] fo_offer,
  // Detected by the converter
  output logic copper_an_capable,
  output logic fiber_an_capable,
  output logic fiber_flp_rx,
  output logic [3:0] copper_abil,
  output logic [3:0] fiber_abil
);
  always_ff @(posedge mclk) begin
    copper_an_capable <= cu_neg;
    fiber_an_capable <= fo_neg;
    fiber_flp_rx <= fo_neg & fo_burst;
  end
  always_ff @(posedge mclk) begin
    copper_abil <= cu_offer;
    fiber_abil <= fo_offer;
  end
endmodule : mcc_link_partner

/* bench/media_converter_mode_config_bench.sv */
/*
  Self-checking bench: APB master tasks, strap and pin stimulus, partners.
  Assumes the strap delay parameter is shortened to keep the run brief.
*/
`timescale 1ns/1ps
module media_converter_mode_config_bench;
  localparam int unsigned STRAP_DELAY = 20;
  logic mclk, sys_rst, psel, penable, pwrite, pready, pslverr, er;
  logic [9:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [1:0] speed_strap, duplex_strap, copper_port_style_strap, fiber_port_style_strap;
  logic [1:0] addr_bit4_warning_strap, addr_bits_upper_strap, addr_bits_lower_strap;
  logic backup_link_pin_i, backup_link_pin_o, backup_link_pin_oe_n, backup_fail;
  logic copper_output_disable_n, fiber_output_disable_n, power_down_n;
  logic copper_an_capable, fiber_an_capable, fiber_flp_rx, cu_neg, fo_neg, fo_burst;
  logic [3:0] copper_abil, fiber_abil, copper_adv, fiber_adv, cu_offer, fo_offer;
  logic [5:0] mgmt_addr;
  logic [1:0] resolved_abil, copper_coding, fiber_coding;
  logic own_flp_en, link_integrity_warning, transparent_active, copper_pecl;
  logic fiber_differential, fiber_peaking_en, copper_out_en, fiber_out_en, strap_latched;
  int err_total, checked;
  logic [9:0] abil_tbl [5] = '{10'h3FF, 10'h1FE, 10'h0ED, 10'h044, 10'h323};
  logic [19:0] latch_tbl [2] = '{{mcc_pkg::LVL3_VCC, mcc_pkg::LVL3_VCC, 16'h5A88},
    {mcc_pkg::LVL3_GND, mcc_pkg::LVL3_GND, 16'h5F88}};
  mcc_mode_config #(.STRAP_DELAY(STRAP_DELAY)) u_mcc_mode_config (.*);
  mcc_link_partner u_mcc_link_partner (.mclk(mclk), .cu_neg(cu_neg), .fo_neg(fo_neg),
    .fo_burst(fo_burst), .cu_offer(cu_offer), .fo_offer(fo_offer),
    .copper_an_capable(copper_an_capable), .fiber_an_capable(fiber_an_capable),
    .fiber_flp_rx(fiber_flp_rx), .copper_abil(copper_abil), .fiber_abil(fiber_abil));
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  task automatic conclude;
    $display("Comparisons %0d, mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : conclude
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      err_total++;
    end
  endtask : cmp
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
  endtask : tick
  // The request is held until pready is seen high at a rising edge.
  task automatic xfer(input logic w, input logic [9:0] a, input logic [31:0] wd);
    int n;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge mclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      cmp(32'(pready), 32'h1);
      conclude();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask : xfer
  task automatic wait_latch;
    int n;
    tick(6);
    n = 0;
    while (strap_latched !== 1'b1 && n < 200) begin
      @(posedge mclk);
      n++;
    end
    if (n >= 200) begin
      cmp(32'(strap_latched), 32'h1);
      conclude();
    end
  endtask : wait_latch
  initial begin
    err_total = 0;
    checked = 0;
    sys_rst = 1'b1;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    speed_strap = mcc_pkg::LVL3_MID;
    duplex_strap = mcc_pkg::LVL3_MID;
    copper_port_style_strap = mcc_pkg::LVL4_VCC;
    fiber_port_style_strap = mcc_pkg::LVL4_THIRD;
    addr_bit4_warning_strap = 2'h2;
    addr_bits_upper_strap = 2'h0;
    addr_bits_lower_strap = 2'h0;
    {backup_link_pin_i, backup_fail} = 2'b10;
    {copper_output_disable_n, fiber_output_disable_n, power_down_n} = 3'b111;
    {cu_neg, fo_neg, fo_burst, cu_offer, fo_offer} = '0;
    tick(10);
    sys_rst <= 1'b0;
    xfer(1'b0, mcc_pkg::ADDR_REG28, 32'h0);
    cmp(rd, 32'h0);
    xfer(1'b0, mcc_pkg::ADDR_REG30, 32'h0);
    cmp(rd, 32'h0);
    wait_latch();
    xfer(1'b0, mcc_pkg::ADDR_REG30, 32'h0);
    cmp(rd, 32'h1088);
    xfer(1'b0, mcc_pkg::ADDR_REG28, 32'h0);
    cmp(rd, 32'h2);
    cmp(32'(transparent_active), 32'h1);
    cmp(32'(link_integrity_warning), 32'h0);
    cmp(32'(copper_pecl), 32'h1);
    cmp(32'(fiber_differential), 32'h1);
    cmp(32'(backup_link_pin_oe_n), 32'h0);
    cmp(32'(fiber_peaking_en), 32'h0);
    cmp(32'(copper_coding), 32'(mcc_pkg::CU_PECL));
    for (int i = 0; i < 5; i++) begin
      cu_offer <= abil_tbl[i][9:6];
      fo_offer <= abil_tbl[i][5:2];
      tick(6);
      cmp(32'(resolved_abil), 32'(abil_tbl[i][1:0]));
      cmp(32'(fiber_adv), 32'(abil_tbl[i][9:6]));
      cmp(32'(copper_adv), 32'(abil_tbl[i][5:2]));
    end
    addr_bit4_warning_strap <= 2'h1;
    addr_bits_upper_strap <= 2'h1;
    addr_bits_lower_strap <= 2'h3;
    copper_output_disable_n <= 1'b0;
    fiber_output_disable_n <= 1'b0;
    backup_fail <= 1'b1;
    tick(5);
    cmp(32'(mgmt_addr), 32'h17);
    cmp(32'(copper_out_en), 32'h0);
    cmp(32'(fiber_out_en), 32'h0);
    cmp(32'(backup_link_pin_o), 32'h1);
    {copper_output_disable_n, fiber_output_disable_n, backup_fail} <= 3'b110;
    tick(5);
    cmp(32'(backup_link_pin_o), 32'h0);
    cmp(32'(copper_out_en), 32'h1);
    cmp(32'(fiber_out_en), 32'h1);
    xfer(1'b1, mcc_pkg::ADDR_REG30, 32'hABCD1000);
    xfer(1'b0, mcc_pkg::ADDR_REG30, 32'h0);
    cmp(rd, 32'h1000);
    cmp(32'(copper_pecl), 32'h0);
    cmp(32'(fiber_differential), 32'h0);
    cmp(32'(fiber_peaking_en), 32'h1);
    cmp(32'(copper_coding), 32'(mcc_pkg::CU_MLT3));
    cmp(32'(fiber_coding), 32'(mcc_pkg::FO_NRZI));
    cmp(32'(link_integrity_warning), 32'h0);
    xfer(1'b1, mcc_pkg::ADDR_REG30, 32'h0800);
    {cu_neg, fo_neg, fo_burst} <= 3'b111;
    tick(6);
    cmp(32'(own_flp_en), 32'h0);
    cmp(32'(copper_coding), 32'(mcc_pkg::CU_FLP));
    cmp(32'(fiber_coding), 32'(mcc_pkg::FO_FLNP));
    xfer(1'b0, mcc_pkg::ADDR_STAT, 32'h0);
    cmp(32'(rd[6]), 32'h1);
    xfer(1'b0, 10'h3FC, 32'h0);
    cmp(32'(er), 32'h1);
    cmp(rd, 32'h0);
    {fo_neg, cu_offer, fo_offer} <= 9'h031;
    tick(8);
    cmp(32'(own_flp_en), 32'h1);
    cmp(32'(fiber_coding), 32'(mcc_pkg::FO_MANCH));
    {cu_neg, cu_offer} <= 5'h00;
    tick(8);
    cmp(32'(copper_coding), 32'(mcc_pkg::CU_MANCH));
    cmp(32'(fiber_coding), 32'(mcc_pkg::FO_IDLE));
    for (int i = 0; i < 2; i++) begin
      speed_strap <= latch_tbl[i][19:18];
      duplex_strap <= latch_tbl[i][17:16];
      xfer(1'b1, mcc_pkg::ADDR_REG30, 32'h0);
      if (i == 0) begin
        power_down_n <= 1'b0;
        tick(4);
        power_down_n <= 1'b1;
      end else begin
        xfer(1'b1, mcc_pkg::ADDR_REG30, 32'h2000);
        xfer(1'b1, mcc_pkg::ADDR_REG30, 32'h0);
      end
      wait_latch();
      xfer(1'b0, mcc_pkg::ADDR_REG30, 32'h0);
      cmp(rd, 32'(latch_tbl[i][15:0]));
      cmp(32'(transparent_active), 32'h0);
      cmp(32'(link_integrity_warning), 32'h1);
    end
    conclude();
  end
endmodule : media_converter_mode_config_bench
bind mcc_mode_config mcc_mode_config_monitor #(.STRAP_DELAY(STRAP_DELAY))
  u_mcc_mode_config_monitor (.mclk(mclk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
  .paddr(paddr), .pready(pready), .pslverr(pslverr),
  .addr_bit4_warning_strap(addr_bit4_warning_strap),
  .addr_bits_upper_strap(addr_bits_upper_strap),
  .addr_bits_lower_strap(addr_bits_lower_strap),
  .copper_output_disable_n(copper_output_disable_n),
  .fiber_output_disable_n(fiber_output_disable_n), .power_down_n(power_down_n),
  .fiber_flp_rx(fiber_flp_rx), .copper_abil(copper_abil), .fiber_abil(fiber_abil),
  .mgmt_addr(mgmt_addr), .copper_adv(copper_adv), .fiber_adv(fiber_adv),
  .own_flp_en(own_flp_en), .link_integrity_warning(link_integrity_warning),
  .transparent_active(transparent_active), .copper_out_en(copper_out_en),
  .fiber_out_en(fiber_out_en), .strap_latched(strap_latched));
